// ### rtl/ee_pkg.sv
package ee_pkg;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_NS = 40;
   localparam int SCL_NS = 2500;
   localparam int QTR_CYCLES = SCL_NS / CLK_NS / 4;
   localparam int WR_TIME_NS = 4000000;
   localparam int WR_CYCLES_DEF = WR_TIME_NS / CLK_NS;
   // ----------------------------------------
   // addressing and sizes
   // ----------------------------------------
   localparam logic [3:0] DEV_TYPE = 4'h5; // arbitrary value
   localparam int ADDR_W = 13;
   localparam int MEM_BYTES = 8192;
   localparam int HI_BITS = 5;
   localparam int PAGE_BITS = 5;
   localparam int LEN_W = 8;
   localparam int FIFO_WIDTH = 8;
   localparam int FIFO_DEPTH = 8;
   localparam logic SYNC_RST = 1'b1;
   // ----------------------------------------
   // states
   // ----------------------------------------
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_RX = 3'b001,
      S_RX_ACK = 3'b010,
      S_TX = 3'b011,
      S_TX_ACK = 3'b100
   } slv_state_t;
   typedef enum logic [1:0] {
      M_IDLE = 2'b00,
      M_START = 2'b01,
      M_BIT = 2'b10,
      M_STOP = 2'b11
   } mst_state_t;
   typedef enum logic [2:0] {
      P_DEVW = 3'b000,
      P_HI = 3'b001,
      P_LO = 3'b010,
      P_DEVR = 3'b011,
      P_READ = 3'b100
   } step_t;
endpackage

// ### rtl/ee_link_if.sv
`timescale 1ns/1ps
// two-wire link; data line is wired-and of both open-drain ends
interface ee_link_if;
   logic scl;
   logic m_sda_o;
   logic m_sda_oe;
   logic s_sda_o;
   logic s_sda_oe;
   logic sda;
   // resolve open-drain data line, pulled high when nobody drives low
   assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));
   modport master (output scl, output m_sda_o, output m_sda_oe, input sda);
   modport slave (input scl, input sda, output s_sda_o, output s_sda_oe);
endinterface

// ### rtl/ee_read_slave.sv
`timescale 1ns/1ps
module ee_read_slave #(
   parameter int WR_CYCLES = ee_pkg::WR_CYCLES_DEF // write cycle in clocks
)
(
   input wire logic core_clk, // system clock
   input wire logic resetn, // async reset, active low
   ee_link_if.slave link, // two-wire bus, device end
   input wire logic select_pin_high, // select strap, top bit
   input wire logic select_pin_mid, // select strap, middle bit
   input wire logic select_pin_low, // select strap, low bit
   output logic busy // internal write cycle running
);
   localparam int AW = ee_pkg::ADDR_W;
   localparam int HB = ee_pkg::HI_BITS;
   localparam int PB = ee_pkg::PAGE_BITS;
   localparam int BW = $clog2(WR_CYCLES + 1);

   // ----------------------------------------
   // state
   // ----------------------------------------
   ee_pkg::slv_state_t state_r, state_nxt;
   logic [3:0] bit_r, bit_nxt;
   logic [1:0] byte_r, byte_nxt;
   logic [7:0] sh_r, sh_nxt;
   logic [HB-1:0] hi_r, hi_nxt;
   logic [AW-1:0] addr_r, addr_nxt;
   logic rd_mode_r, rd_mode_nxt;
   logic mack_r, mack_nxt;
   logic oe_r, oe_nxt;
   logic wrote_r, wrote_nxt;
   logic [BW-1:0] busy_r, busy_nxt;
   logic busy_q_r, busy_q_nxt;
   logic [7:0] mem [0:ee_pkg::MEM_BYTES-1];
   logic mem_we;
   logic [7:0] rd_byte;
   logic scl_s1, scl_s2, scl_p;
   logic sda_s1, sda_s2, sda_p;
   logic scl_rise, scl_fall, start_det, stop_det;
   logic match;

   // ----------------------------------------
   // pin synchronisers and edge finding
   // ----------------------------------------
   // two flops per pin, then one more for edge history
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         scl_s1 <= ee_pkg::SYNC_RST;
         scl_s2 <= ee_pkg::SYNC_RST;
         scl_p <= ee_pkg::SYNC_RST;
         sda_s1 <= ee_pkg::SYNC_RST;
         sda_s2 <= ee_pkg::SYNC_RST;
         sda_p <= ee_pkg::SYNC_RST;
      end
      else
      begin
         scl_s1 <= link.scl;
         scl_s2 <= scl_s1;
         scl_p <= scl_s2;
         sda_s1 <= link.sda;
         sda_s2 <= sda_s1;
         sda_p <= sda_s2;
      end
   end

   // bus events seen on the core clock
   assign scl_rise = scl_s2 && !scl_p;
   assign scl_fall = !scl_s2 && scl_p;
   assign start_det = scl_s2 && scl_p && sda_p && !sda_s2;
   assign stop_det = scl_s2 && scl_p && !sda_p && sda_s2;

   // address byte check against type code and straps
   assign match = (sh_r[7:4] == ee_pkg::DEV_TYPE) &&
                  (sh_r[3:1] == {select_pin_high, select_pin_mid, select_pin_low});
   assign rd_byte = mem[addr_r];

   // ----------------------------------------
   // protocol engine
   // ----------------------------------------
   // next-state logic for the byte engine
   always_comb
   begin
      state_nxt = state_r;
      bit_nxt = bit_r;
      byte_nxt = byte_r;
      sh_nxt = sh_r;
      hi_nxt = hi_r;
      addr_nxt = addr_r;
      rd_mode_nxt = rd_mode_r;
      mack_nxt = mack_r;
      oe_nxt = oe_r;
      wrote_nxt = wrote_r;
      mem_we = 1'b0;
      busy_nxt = (busy_r != '0) ? busy_r - BW'(1) : busy_r;
      if (start_det)
      begin
         // start or repeated start: new address phase
         state_nxt = ee_pkg::S_RX;
         bit_nxt = 4'h0;
         byte_nxt = 2'h0;
         oe_nxt = 1'b0;
      end
      else if (stop_det)
      begin
         // stop: release line, back to standby
         state_nxt = ee_pkg::S_IDLE;
         oe_nxt = 1'b0;
         if (wrote_r)
         begin
            busy_nxt = BW'(WR_CYCLES);
            wrote_nxt = 1'b0;
         end
      end
      else
      begin
         case (state_r)
            ee_pkg::S_RX:
            begin
               if (scl_rise && bit_r != 4'h8)
               begin
                  sh_nxt = {sh_r[6:0], sda_s2};
                  bit_nxt = bit_r + 4'h1;
               end
               else if (scl_fall && bit_r == 4'h8)
               begin
                  // eighth bit done: decide ack for the ninth clock
                  state_nxt = ee_pkg::S_RX_ACK;
                  oe_nxt = 1'b1;
                  byte_nxt = (byte_r == 2'h3) ? byte_r : byte_r + 2'h1;
                  case (byte_r)
                     2'h0:
                     begin
                        rd_mode_nxt = sh_r[0];
                        if (!match || busy_r != '0)
                        begin
                           state_nxt = ee_pkg::S_IDLE;
                           oe_nxt = 1'b0;
                        end
                     end
                     2'h1: hi_nxt = sh_r[HB-1:0];
                     2'h2: addr_nxt = {hi_r, sh_r};
                     default:
                     begin
                        // data byte of a write, kept within the page
                        mem_we = 1'b1;
                        wrote_nxt = 1'b1;
                        addr_nxt = {addr_r[AW-1:PB], addr_r[PB-1:0] + PB'(1)};
                     end
                  endcase
               end
            end
            ee_pkg::S_RX_ACK:
            begin
               if (scl_fall)
               begin
                  bit_nxt = 4'h0;
                  if (rd_mode_r)
                  begin
                     // first read byte at the counter, counter steps on
                     state_nxt = ee_pkg::S_TX;
                     sh_nxt = rd_byte;
                     oe_nxt = !rd_byte[7];
                     addr_nxt = addr_r + AW'(1);
                  end
                  else
                  begin
                     state_nxt = ee_pkg::S_RX;
                     oe_nxt = 1'b0;
                  end
               end
            end
            ee_pkg::S_TX:
            begin
               if (scl_fall)
               begin
                  if (bit_r == 4'h7)
                  begin
                     state_nxt = ee_pkg::S_TX_ACK;
                     oe_nxt = 1'b0;
                  end
                  else
                  begin
                     sh_nxt = {sh_r[6:0], 1'b0};
                     oe_nxt = !sh_r[6];
                     bit_nxt = bit_r + 4'h1;
                  end
               end
            end
            ee_pkg::S_TX_ACK:
            begin
               if (scl_rise)
               begin
                  mack_nxt = !sda_s2;
               end
               else if (scl_fall)
               begin
                  bit_nxt = 4'h0;
                  if (mack_r)
                  begin
                     // master acked: next byte, no address phase
                     state_nxt = ee_pkg::S_TX;
                     sh_nxt = rd_byte;
                     oe_nxt = !rd_byte[7];
                     addr_nxt = addr_r + AW'(1);
                  end
                  else
                  begin
                     state_nxt = ee_pkg::S_IDLE;
                  end
               end
            end
            default:
            begin
               state_nxt = ee_pkg::S_IDLE;
            end
         endcase
      end
      busy_q_nxt = (busy_nxt != '0);
   end

   // register the byte engine
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_r <= ee_pkg::S_IDLE;
         bit_r <= 4'h0;
         byte_r <= 2'h0;
         sh_r <= 8'h00;
         hi_r <= '0;
         addr_r <= '0;
         rd_mode_r <= 1'b0;
         mack_r <= 1'b0;
         oe_r <= 1'b0;
         wrote_r <= 1'b0;
         busy_r <= '0;
         busy_q_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         bit_r <= bit_nxt;
         byte_r <= byte_nxt;
         sh_r <= sh_nxt;
         hi_r <= hi_nxt;
         addr_r <= addr_nxt;
         rd_mode_r <= rd_mode_nxt;
         mack_r <= mack_nxt;
         oe_r <= oe_nxt;
         wrote_r <= wrote_nxt;
         busy_r <= busy_nxt;
         busy_q_r <= busy_q_nxt;
      end
   end

   // ----------------------------------------
   // storage array
   // ----------------------------------------
   // byte array, erased at start, written by write-direction data bytes
   initial
   begin
      for (int k = 0; k < ee_pkg::MEM_BYTES; k++)
         mem[k] = 8'hff;
   end
   always @(posedge core_clk)
   begin
      if (mem_we)
      begin
         mem[addr_r] <= sh_r;
      end
   end

   // open-drain output: only ever pulls low
   assign link.s_sda_o = 1'b0;
   assign link.s_sda_oe = oe_r;
   assign busy = busy_q_r;
endmodule

// ### rtl/ee_read_master.sv
`timescale 1ns/1ps
// byte FIFO between link engine and user
module ee_byte_fifo #(
   parameter int WIDTH = ee_pkg::FIFO_WIDTH, // word width
   parameter int DEPTH = ee_pkg::FIFO_DEPTH // words, power of two
)
(
   input wire logic core_clk, // system clock
   input wire logic resetn, // async reset, active low
   input wire logic in_valid, // write request
   output logic in_ready, // room for a word
   input wire logic [WIDTH-1:0] in_data, // word written
   output logic out_valid, // word available
   input wire logic out_ready, // reader takes word
   output logic [WIDTH-1:0] out_data // oldest word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic push, pop;

   // pointer and count update
   always_comb
   begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      wp_nxt = push ? wp_r + AW'(1) : wp_r;
      rp_nxt = pop ? rp_r + AW'(1) : rp_r;
      cnt_nxt = cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (push)
      begin
         mem[wp_r] <= in_data;
      end
   end

   assign in_ready = (cnt_r != (AW + 1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem[rp_r];
endmodule

// bus master issuing current-address and chosen-location reads
module ee_read_master #(
   parameter int QTR = ee_pkg::QTR_CYCLES // clocks per quarter bit
)
(
   input wire logic core_clk, // system clock
   input wire logic resetn, // async reset, active low
   ee_link_if.master link, // two-wire bus, master end
   input wire logic cmd_valid, // read request
   output logic cmd_ready, // idle, request taken
   input wire logic cmd_random, // 1: load address first
   input wire logic [ee_pkg::ADDR_W-1:0] cmd_addr, // start address
   input wire logic [ee_pkg::LEN_W-1:0] cmd_len, // bytes, 0 as 1
   input wire logic [2:0] cmd_sel, // device select bits
   output logic [7:0] rd_data, // byte read
   output logic rd_valid, // byte available
   input wire logic rd_ready, // user takes byte
   output logic done, // transfer ended, pulse
   output logic nack // device refused a byte
);
   localparam int TW = $clog2(QTR + 1);
   localparam int LW = ee_pkg::LEN_W;
   ee_pkg::mst_state_t st_r, st_nxt;
   ee_pkg::step_t step_r, step_nxt;
   logic [1:0] ph_r, ph_nxt;
   logic [TW-1:0] tm_r, tm_nxt;
   logic [3:0] bit_r, bit_nxt;
   logic [7:0] sh_r, sh_nxt;
   logic [LW-1:0] left_r, left_nxt;
   logic [ee_pkg::ADDR_W-1:0] addr_r, addr_nxt;
   logic [2:0] sel_r, sel_nxt;
   logic scl_r, scl_nxt, rel_r, rel_nxt;
   logic rdy_r, rdy_nxt, done_r, done_nxt, nack_r, nack_nxt;
   logic sda_s1, sda_s2;
   logic tick, hold, push, room;

   // byte sent for each step of a transfer
   function automatic logic [7:0] load_byte(input ee_pkg::step_t s, input logic [2:0] sel,
      input logic [ee_pkg::ADDR_W-1:0] a);
      case (s)
         ee_pkg::P_DEVW: load_byte = {ee_pkg::DEV_TYPE, sel, 1'b0};
         ee_pkg::P_HI: load_byte = 8'(a >> 8);
         ee_pkg::P_LO: load_byte = a[7:0];
         ee_pkg::P_DEVR: load_byte = {ee_pkg::DEV_TYPE, sel, 1'b1};
         default: load_byte = 8'hff;
      endcase
   endfunction

   // received bytes wait here for the user
   ee_byte_fifo #(.WIDTH(8), .DEPTH(ee_pkg::FIFO_DEPTH)) ee_byte_fifo_inst (
      .core_clk(core_clk), .resetn(resetn), .in_valid(push), .in_ready(room),
      .in_data(sh_r), .out_valid(rd_valid), .out_ready(rd_ready), .out_data(rd_data));

   // data pin synchroniser
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
      end
      else
      begin
         sda_s1 <= link.sda;
         sda_s2 <= sda_s1;
      end
   end

   // quarter-bit sequencer; actions happen on leaving each phase
   always_comb
   begin
      st_nxt = st_r;
      step_nxt = step_r;
      ph_nxt = ph_r;
      bit_nxt = bit_r;
      sh_nxt = sh_r;
      left_nxt = left_r;
      addr_nxt = addr_r;
      sel_nxt = sel_r;
      scl_nxt = scl_r;
      rel_nxt = rel_r;
      rdy_nxt = rdy_r;
      nack_nxt = nack_r;
      done_nxt = 1'b0;
      push = 1'b0;
      tick = (tm_r == TW'(QTR - 1));
      // buffer full: keep the clock low before the ack slot
      hold = (st_r == ee_pkg::M_BIT) && (step_r == ee_pkg::P_READ) && (bit_r == 4'h8) &&
             (ph_r == 2'h0) && !room;
      tm_nxt = (tick || st_r == ee_pkg::M_IDLE) ? '0 : tm_r + TW'(1);
      if (hold)
         tm_nxt = tm_r;
      case (st_r)
         ee_pkg::M_IDLE:
         begin
            rdy_nxt = 1'b1;
            if (cmd_valid && rdy_r)
            begin
               rdy_nxt = 1'b0;
               st_nxt = ee_pkg::M_START;
               ph_nxt = 2'h0;
               step_nxt = cmd_random ? ee_pkg::P_DEVW : ee_pkg::P_DEVR;
               addr_nxt = cmd_addr;
               sel_nxt = cmd_sel;
               nack_nxt = 1'b0;
               left_nxt = (cmd_len == '0) ? LW'(1) : cmd_len;
            end
         end
         ee_pkg::M_START:
         begin
            if (tick)
            begin
               ph_nxt = ph_r + 2'h1;
               case (ph_r)
                  2'h0: rel_nxt = 1'b1;
                  2'h1: scl_nxt = 1'b1;
                  2'h2: rel_nxt = 1'b0; // start or repeated start
                  default:
                  begin
                     scl_nxt = 1'b0;
                     st_nxt = ee_pkg::M_BIT;
                     bit_nxt = 4'h0;
                     sh_nxt = load_byte(step_r, sel_r, addr_r);
                  end
               endcase
            end
         end
         ee_pkg::M_BIT:
         begin
            if (tick && !hold)
            begin
               ph_nxt = ph_r + 2'h1;
               case (ph_r)
                  2'h0:
                  begin
                     if (bit_r != 4'h8)
                        rel_nxt = (step_r == ee_pkg::P_READ) || sh_r[7];
                     else if (step_r == ee_pkg::P_READ)
                     begin
                        rel_nxt = (left_r == LW'(1)); // last byte: NoACK
                        push = 1'b1;
                        left_nxt = left_r - LW'(1);
                     end
                     else
                        rel_nxt = 1'b1;
                  end
                  2'h1: scl_nxt = 1'b1;
                  2'h2:
                  begin
                     if (bit_r != 4'h8 && step_r == ee_pkg::P_READ)
                        sh_nxt = {sh_r[6:0], sda_s2};
                     else if (bit_r == 4'h8 && step_r != ee_pkg::P_READ && sda_s2)
                        nack_nxt = 1'b1;
                  end
                  default:
                  begin
                     scl_nxt = 1'b0;
                     bit_nxt = bit_r + 4'h1;
                     if (step_r != ee_pkg::P_READ)
                        sh_nxt = {sh_r[6:0], 1'b0};
                     if (bit_r == 4'h8)
                     begin
                        bit_nxt = 4'h0;
                        if (nack_r || (step_r == ee_pkg::P_READ && left_r == '0))
                           st_nxt = ee_pkg::M_STOP;
                        else if (step_r == ee_pkg::P_LO)
                        begin
                           st_nxt = ee_pkg::M_START;
                           step_nxt = ee_pkg::P_DEVR;
                        end
                        else
                        begin
                           if (step_r == ee_pkg::P_DEVW)
                              step_nxt = ee_pkg::P_HI;
                           else if (step_r == ee_pkg::P_HI)
                              step_nxt = ee_pkg::P_LO;
                           else
                              step_nxt = ee_pkg::P_READ;
                           sh_nxt = load_byte(step_nxt, sel_r, addr_r);
                        end
                     end
                  end
               endcase
            end
         end
         ee_pkg::M_STOP:
         begin
            if (tick)
            begin
               ph_nxt = ph_r + 2'h1;
               case (ph_r)
                  2'h0: rel_nxt = 1'b0;
                  2'h1: scl_nxt = 1'b1;
                  2'h2: rel_nxt = 1'b1; // stop closes the transfer
                  default:
                  begin
                     st_nxt = ee_pkg::M_IDLE;
                     done_nxt = 1'b1;
                  end
               endcase
            end
         end
         default:
         begin
            st_nxt = ee_pkg::M_IDLE;
         end
      endcase
   end

   // register the sequencer
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st_r <= ee_pkg::M_IDLE;
         step_r <= ee_pkg::P_DEVW;
         ph_r <= 2'h0;
         tm_r <= '0;
         bit_r <= 4'h0;
         sh_r <= 8'h00;
         left_r <= '0;
         addr_r <= '0;
         sel_r <= 3'h0;
         scl_r <= 1'b1;
         rel_r <= 1'b1;
         rdy_r <= 1'b0;
         done_r <= 1'b0;
         nack_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         step_r <= step_nxt;
         ph_r <= ph_nxt;
         tm_r <= tm_nxt;
         bit_r <= bit_nxt;
         sh_r <= sh_nxt;
         left_r <= left_nxt;
         addr_r <= addr_nxt;
         sel_r <= sel_nxt;
         scl_r <= scl_nxt;
         rel_r <= rel_nxt;
         rdy_r <= rdy_nxt;
         done_r <= done_nxt;
         nack_r <= nack_nxt;
      end
   end

   // open-drain data, clock driven from a flop
   assign link.scl = scl_r;
   assign link.m_sda_o = 1'b0;
   assign link.m_sda_oe = !rel_r;
   assign cmd_ready = rdy_r;
   assign done = done_r;
   assign nack = nack_r;
endmodule

// ### tb/ee_link_asserts.sv
`timescale 1ns/1ps
// watches the two-wire link between both ends
module ee_link_asserts (
   input wire logic core_clk, // system clock
   input wire logic resetn, // reset, active low
   input wire logic scl, // link clock
   input wire logic m_sda_o, // master data
   input wire logic m_sda_oe, // master enable
   input wire logic s_sda_o, // device data
   input wire logic s_sda_oe, // device enable
   input wire logic sda // resolved data
);
   logic scl_r, sda_r, fr_r, fr_nxt, first_r, first_nxt, rd_r, rd_nxt, ack_r, ack_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [7:0] byte_r, byte_nxt;
   wire logic m_low = m_sda_oe && !m_sda_o;
   wire logic s_low = s_sda_oe && !s_sda_o;
   wire logic rise = scl && !scl_r;
   wire logic start_ev = scl && scl_r && sda_r && !sda;
   wire logic stop_ev = scl && scl_r && !sda_r && sda;
   wire logic ninth = rise && cnt_r == 4'h8;
   // frame tracking: bit count, first byte, direction
   always_comb
   begin
      fr_nxt = fr_r;
      first_nxt = first_r;
      rd_nxt = rd_r;
      ack_nxt = ack_r;
      cnt_nxt = cnt_r;
      byte_nxt = byte_r;
      if (start_ev)
      begin
         fr_nxt = 1'b1;
         first_nxt = 1'b1;
         rd_nxt = 1'b0;
         ack_nxt = 1'b0;
         cnt_nxt = 4'h0;
      end
      else if (stop_ev)
         fr_nxt = 1'b0;
      else if (ninth)
      begin
         cnt_nxt = 4'h0;
         first_nxt = 1'b0;
         if (first_r)
         begin
            rd_nxt = byte_r[0];
            ack_nxt = s_low;
         end
      end
      else if (rise)
      begin
         cnt_nxt = cnt_r + 4'h1;
         byte_nxt = {byte_r[6:0], sda};
      end
   end
   // registers only
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         scl_r <= 1'b1;
         sda_r <= 1'b1;
         fr_r <= 1'b0;
         first_r <= 1'b0;
         rd_r <= 1'b0;
         ack_r <= 1'b0;
         cnt_r <= 4'h0;
         byte_r <= 8'h00;
      end
      else
      begin
         scl_r <= scl;
         sda_r <= sda;
         fr_r <= fr_nxt;
         first_r <= first_nxt;
         rd_r <= rd_nxt;
         ack_r <= ack_nxt;
         cnt_r <= cnt_nxt;
         byte_r <= byte_nxt;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   a_type_ack: assert property (ninth && first_r && s_low |-> byte_r[7:4] == ee_pkg::DEV_TYPE)
      else $error("device acked a foreign type code");
   a_rx_ack: assert property (ninth && ack_r && !first_r && !rd_r |-> s_low)
      else $error("device refused an address byte");
   a_tx_release: assert property (ninth && rd_r |-> !s_low)
      else $error("device held data in master ack slot");
   a_rx_quiet: assert property (rise && fr_r && !ninth && !rd_r |-> !s_low)
      else $error("device drove data while receiving");
   a_mst_quiet: assert property (rise && rd_r && cnt_r != 4'h0 && !ninth |-> !m_low)
      else $error("master drove data while device sends");
   a_change_low: assert property ($changed(s_low) |-> !scl)
      else $error("device data changed with clock high");
   a_idle_quiet: assert property (!fr_r |-> !s_low)
      else $error("device drove data outside a frame");
   a_scl_idle: assert property (!fr_r |-> scl)
      else $error("link clock low outside a frame");
   c_seq_ack: cover property (ninth && rd_r && !sda);
   c_addr_nack: cover property (ninth && first_r && !s_low);
   c_restart: cover property (start_ev && fr_r);
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
   logic core_clk, resetn, cmd_valid, cmd_ready, cmd_random, rd_valid, rd_ready, done, nack;
   logic busy, stall;
   logic [ee_pkg::ADDR_W-1:0] cmd_addr;
   logic [ee_pkg::LEN_W-1:0] cmd_len;
   logic [7:0] rd_data;
   logic [2:0] cmd_sel, pins;
   logic [31:0] seed, rseed;
   int fails, total_checks, i;
   logic [7:0] exp_data[$];
   logic exp_nack[$];
   ee_link_if link ();
   ee_read_slave #(.WR_CYCLES(100)) ee_read_slave_inst (.core_clk(core_clk),
      .resetn(resetn), .link(link), .select_pin_high(pins[2]), .select_pin_mid(pins[1]),
      .select_pin_low(pins[0]), .busy(busy));
   ee_read_master #(.QTR(2)) ee_read_master_inst (.core_clk(core_clk), .resetn(resetn),
      .link(link), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_random(cmd_random),
      .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_sel(cmd_sel), .rd_data(rd_data),
      .rd_valid(rd_valid), .rd_ready(rd_ready), .done(done), .nack(nack));
   ee_link_asserts ee_link_asserts_inst (.core_clk(core_clk), .resetn(resetn),
      .scl(link.scl), .m_sda_o(link.m_sda_o), .m_sda_oe(link.m_sda_oe),
      .s_sda_o(link.s_sda_o), .s_sda_oe(link.s_sda_oe), .sda(link.sda));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // note expected bytes (erased memory), then hand the request over
   task automatic issue(input logic rnd, input logic [12:0] addr, input logic [7:0] len,
      input logic [2:0] sel);
      int n;
      @(posedge core_clk);
      #1;
      if (sel === pins)
         for (n = 0; n < ((len == 8'h00) ? 1 : int'(len)); n++)
            exp_data.push_back(8'hff);
      exp_nack.push_back(sel !== pins);
      cmd_random = rnd;
      cmd_addr = addr;
      cmd_len = len;
      cmd_sel = sel;
      cmd_valid = 1'b1;
      for (n = 0; n < 5000 && cmd_ready !== 1'b1; n++)
         @(negedge core_clk);
      if (n == 5000)
      begin
         fails++;
         $display("unexpected cmd_ready: expected 1, seen %b", cmd_ready);
         end_of_test();
      end
      @(posedge core_clk);
      #1;
      cmd_valid = 1'b0;
   endtask
   // clock
   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   // user side takes bytes with random pauses
   always @(posedge core_clk)
   begin
      rseed = lfsr(rseed);
      rd_ready <= #1 !stall && (rseed[3] || rseed[7]);
   end
   // compare each result with the oldest note
   always @(negedge core_clk)
      if (resetn === 1'b1)
      begin
         if (rd_valid === 1'b1 && rd_ready === 1'b1)
            check("rd_data", rd_data, (exp_data.size() > 0) ? exp_data.pop_front() : 8'hxx);
         if (done === 1'b1)
            check("nack", {7'h00, nack}, {7'h00, (exp_nack.size() > 0) ? exp_nack.pop_front() : 1'bx});
      end
   // main sequence
   initial
   begin
      resetn = 1'b0;
      {cmd_valid, cmd_random, stall, rd_ready} = 4'h0;
      cmd_addr = 13'h0000;
      cmd_len = 8'h00;
      cmd_sel = 3'h0;
      fails = 0;
      total_checks = 0;
      seed = 32'h47de7ea2;
      rseed = seed;
      pins = seed[2:0];
      repeat (4) @(posedge core_clk);
      #1;
      resetn = 1'b1;
      // chosen-location reads, random place, lengths 0 to 3; then fixed-place, current-address and wrong-select reads
      repeat (4)
      begin
         seed = lfsr(seed);
         issue(1'b1, seed[12:0], {6'h00, seed[14:13]}, pins);
      end
      issue(1'b1, 13'h1ffe, 8'h03, pins);
      issue(1'b0, 13'h0000, 8'h02, pins);
      issue(1'b1, 13'h0010, 8'h01, pins ^ 3'h4);
      issue(1'b0, 13'h0000, 8'h01, pins ^ 3'h1);
      // fill the buffer while the user stalls, then drain
      stall = 1'b1;
      issue(1'b1, seed[12:0], 8'h0c, pins);
      repeat (1500) @(posedge core_clk);
      #1;
      stall = 1'b0;
      for (i = 0; i < 20000 && (exp_nack.size() > 0 || exp_data.size() > 0); i++)
         @(negedge core_clk);
      if (i == 20000)
      begin
         fails++;
         $display("unexpected pending results: expected 0, seen %0d", exp_nack.size());
      end
      check("busy", {7'h00, busy}, 8'h00);
      end_of_test();
   end
endmodule
